//--- verilog/fst_pkg.sv
package fst_pkg;

    // clock and time base
    localparam int CLK_PERIOD_NS = 25;
    localparam int US_NS         = 1000;
    localparam int CYC_PER_US    = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // synchroniser depth ahead of the edge detector
    localparam int SYNC_STAGES = 2;

    // register byte offsets
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_EXPO = 12'h004;
    localparam logic [11:0] REG_CMD  = 12'h008;
    localparam logic [11:0] REG_STAT = 12'h00C;
    localparam logic [11:0] REG_CNT  = 12'h010;

    // control register fields
    localparam int CTRL_TRIG_EN   = 0;
    localparam int CTRL_ORIGIN    = 1;
    localparam int CTRL_POLARITY  = 2;
    localparam int CTRL_EXPO_LEN  = 3;
    localparam int CTRL_KIND      = 4;
    localparam int CTRL_RATE_EN   = 5;
    localparam int CTRL_WIDTH     = 6;
    localparam logic [5:0] CTRL_RESET = 6'h02;

    // command register fields, write only
    localparam int CMD_ACQ_START = 0;
    localparam int CMD_ACQ_STOP  = 1;
    localparam int CMD_SW_KICK   = 2;

    // status register fields
    localparam int STAT_WAITING  = 0;
    localparam int STAT_EXPOSING = 1;
    localparam int STAT_ACQ_ON   = 2;
    localparam int STAT_ARMED    = 3;
    localparam int STAT_OVT      = 4;

    // exposure duration in microseconds
    localparam int          EXPO_WIDTH = 20;
    localparam logic [19:0] EXPO_RESET = 20'h00064;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_WAIT   = 2'b01,
        ST_EXPOSE = 2'b10
    } fst_state_e;

endpackage : fst_pkg

//--- verilog/fst_line_sync.sv
`timescale 1ns/1ps
module fst_line_sync
    import fst_pkg::*;
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic sys_rst,
    // raw line
    input  wire logic lineIn,
    // conditioned line
    output logic      lineLevel,
    output logic      risePulse,
    output logic      fallPulse
);

    logic [SYNC_STAGES-1:0] sync_ff;
    logic                   last_ff;
    logic                   rise_ff;
    logic                   fall_ff;

    // first stage feeds only the second one
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sync_ff <= '0;
            last_ff <= 1'b0;
            rise_ff <= 1'b0;
            fall_ff <= 1'b0;
        end else begin
            sync_ff <= {sync_ff[SYNC_STAGES-2:0], lineIn};
            last_ff <= sync_ff[SYNC_STAGES-1];
            rise_ff <= sync_ff[SYNC_STAGES-1] & ~last_ff; // [RULE_22]
            fall_ff <= ~sync_ff[SYNC_STAGES-1] & last_ff; // [RULE_22]
        end
    end

    assign lineLevel = last_ff;
    assign risePulse = rise_ff;
    assign fallPulse = fall_ff;

    chk_single_edge: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE_22]
        (rise_ff || fall_ff) |=> !(rise_ff || fall_ff))
        else $error("edge pulse lasted more than one cycle");

endmodule : fst_line_sync

//--- verilog/fst_expo_timer.sv
`timescale 1ns/1ps
module fst_expo_timer
    import fst_pkg::*;
#(
    parameter int DUR_W = EXPO_WIDTH
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    // control
    input  wire logic             start,
    input  wire logic [DUR_W-1:0] durationUs,
    // state
    output logic                  running,
    output logic                  expired
);

    localparam logic [5:0] PRE_LAST = 6'(CYC_PER_US - 1);

    logic [5:0]       pre_ff;
    logic [DUR_W-1:0] us_ff;
    logic             run_ff;
    logic             exp_ff;
    wire              usTick  = run_ff && (pre_ff == PRE_LAST);
    wire              lastUs  = (us_ff <= DUR_W'(1));

    // a zero duration still gives one microsecond
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pre_ff <= '0;
            us_ff  <= '0;
            run_ff <= 1'b0;
            exp_ff <= 1'b0;
        end else if (start) begin
            pre_ff <= '0;
            us_ff  <= durationUs;
            run_ff <= 1'b1;
            exp_ff <= 1'b0;
        end else begin
            pre_ff <= usTick ? 6'h00 : (run_ff ? pre_ff + 6'h01 : 6'h00);
            us_ff  <= usTick ? us_ff - DUR_W'(1) : us_ff;
            run_ff <= run_ff && !(usTick && lastUs);
            exp_ff <= usTick && lastUs;
        end
    end

    assign running = run_ff;
    assign expired = exp_ff;

endmodule : fst_expo_timer

//--- verilog/fst_trig_ctrl.sv
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
// Operation
// (RULE_01) software kick starts exposure while waiting
// (RULE_02) leave waiting on start, return when ready
// (RULE_03) host uses timed length with software kicks
// (RULE_04) host keeps kick rate within maximum
// (RULE_05) kick outside waiting is dropped
// (RULE_06) line 1 origin uses line edges
// (RULE_07) polarity chooses rising or falling edge
// (RULE_08) each selected edge while waiting starts frame
// (RULE_09) one frame per line period
// (RULE_10) line edges outside waiting are ignored
// (RULE_11) source keeps edges within maximum rate
// (RULE_12) timed and trigger width lengths selectable
// (RULE_13) timed exposure lasts the duration parameter
// (RULE_14) edge during timed exposure flags overtrigger
// (RULE_15) width rising: expose until line falls
// (RULE_16) width falling: expose until line rises
// (RULE_17) duration parameter times the armed output
// (RULE_18) host sets duration to shortest width
// (RULE_19) kick counts only when kind is frame start
// (RULE_20) waiting needs acquisition start command
// (RULE_21) origin resets to line 1
// (RULE_22) line synchronised, one event per transition
module fst_trig_ctrl
    import fst_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    // axi4-lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // axi4-lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // trigger line
    input  wire logic              external_frame_trigger_line,
    // acquisition status
    output logic                   exposureActive,
    output logic                   waitingTrigger,
    output logic                   triggerArmed,
    output logic                   overtrigPulse
);

    ////////////////////////////////////////////////////////////////////////
    // bus slave state

    logic              awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic              awHeld_ff, wHeld_ff;
    logic [ADDR_W-1:0] awAddr_ff;
    logic [31:0]       wData_ff;
    logic [3:0]        wStrb_ff;
    logic [1:0]        bresp_ff, rresp_ff;
    logic [31:0]       rdata_ff;

    wire awTake  = s_axi_awvalid && awready_ff;
    wire wTake   = s_axi_wvalid && wready_ff;
    wire doWrite = awHeld_ff && wHeld_ff && !bvalid_ff;
    wire arTake  = s_axi_arvalid && arready_ff;

    wire [11:0] wOff = 12'(awAddr_ff);
    wire [11:0] rOff = 12'(s_axi_araddr);
    wire wrCtrl = doWrite && (wOff == REG_CTRL);
    wire wrExpo = doWrite && (wOff == REG_EXPO);
    wire wrCmd  = doWrite && (wOff == REG_CMD);
    wire wrStat = doWrite && (wOff == REG_STAT);
    wire wrOk   = (wOff == REG_CTRL) || (wOff == REG_EXPO) || (wOff == REG_CMD)
               || (wOff == REG_STAT) || (wOff == REG_CNT);
    wire [31:0] byteMask = {{8{wStrb_ff[3]}}, {8{wStrb_ff[2]}},
                            {8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}};

    ////////////////////////////////////////////////////////////////////////
    // configuration and status registers

    logic [CTRL_WIDTH-1:0] ctrl_ff;
    logic [EXPO_WIDTH-1:0] expo_ff;
    logic                  acqOn_ff;
    logic                  ovtSticky_ff;
    logic [15:0]           frameCnt_ff, ovtCnt_ff;
    fst_state_e            state_ff, nxt_state;
    logic                  expActive_ff, waiting_ff, armed_ff, ovtPulse_ff;

    wire [31:0] expoMerged = ({12'h000, expo_ff} & ~byteMask)
                           | (wData_ff & byteMask);
    wire trigEn    = ctrl_ff[CTRL_TRIG_EN];
    wire fromLine  = ctrl_ff[CTRL_ORIGIN];
    wire fallSel   = ctrl_ff[CTRL_POLARITY];
    wire widthSel  = ctrl_ff[CTRL_EXPO_LEN];
    wire kindFrame = !ctrl_ff[CTRL_KIND];

    wire cmdStart = wrCmd && wStrb_ff[0] && wData_ff[CMD_ACQ_START];
    wire cmdStop  = wrCmd && wStrb_ff[0] && wData_ff[CMD_ACQ_STOP];
    wire cmdKick  = wrCmd && wStrb_ff[0] && wData_ff[CMD_SW_KICK];

    ////////////////////////////////////////////////////////////////////////
    // line conditioning and exposure timer

    logic lineRise, lineFall;
    logic timerRun, timerDone;

    fst_line_sync u_line_sync (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .lineIn    (external_frame_trigger_line),
        .lineLevel (),
        .risePulse (lineRise),
        .fallPulse (lineFall)
    );

    ////////////////////////////////////////////////////////////////////////
    // trigger qualification

    wire selEdge  = fallSel ? lineFall : lineRise;                    // [RULE_07]
    wire endEdge  = fallSel ? lineRise : lineFall;
    wire hwTrig   = trigEn && fromLine && selEdge;                    // [RULE_06]
    wire swTrig   = trigEn && !fromLine && kindFrame && cmdKick;      // [RULE_19]
    wire freeRun  = !trigEn;
    // software frames always use the timed length
    wire widthRun = widthSel && fromLine;                             // [RULE_12]
    wire isWait   = (state_ff == ST_WAIT);                            // [RULE_05] [RULE_10]
    wire isExpose = (state_ff == ST_EXPOSE);
    // a trigger outside waiting starts nothing; a selected edge in timed exposure flags overtrigger
    wire startExp = isWait && (swTrig || hwTrig || freeRun);          // [RULE_01] [RULE_08]
    wire ovtEvent = isExpose && !widthRun && hwTrig;                  // [RULE_14]
    wire expEnd   = widthRun ? endEdge : timerDone;                   // [RULE_15] [RULE_16]

    fst_expo_timer #(
        .DUR_W (EXPO_WIDTH)
    ) u_expo_timer (
        .mclk       (mclk),
        .sys_rst    (sys_rst),
        .start      (startExp),
        .durationUs (expo_ff),
        .running    (timerRun),
        .expired    (timerDone)
    );

    ////////////////////////////////////////////////////////////////////////
    // acquisition state machine

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (cmdStart) begin
                    nxt_state = ST_WAIT;                              // [RULE_20]
                end
            end
            ST_WAIT: begin
                if (cmdStop && !startExp) begin
                    nxt_state = ST_IDLE;
                end else if (startExp) begin
                    nxt_state = ST_EXPOSE;                            // [RULE_02]
                end
            end
            ST_EXPOSE: begin
                if (expEnd) begin
                    nxt_state = (acqOn_ff && !cmdStop) ? ST_WAIT : ST_IDLE; // [RULE_02] [RULE_09]
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_ff     <= ST_IDLE;
            acqOn_ff     <= 1'b0;
            expActive_ff <= 1'b0;
            waiting_ff   <= 1'b0;
            armed_ff     <= 1'b0;
            ovtPulse_ff  <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            acqOn_ff     <= cmdStart ? 1'b1 : (cmdStop ? 1'b0 : acqOn_ff);
            expActive_ff <= (nxt_state == ST_EXPOSE);
            waiting_ff   <= (nxt_state == ST_WAIT);
            // width mode: armed once the shortest exposure has run out
            armed_ff     <= (nxt_state == ST_WAIT)
                         || ((nxt_state == ST_EXPOSE) && widthRun && !timerRun
                             && !startExp);                           // [RULE_17]
            ovtPulse_ff  <= ovtEvent;                                 // [RULE_14]
        end
    end

    // set beats a clear written in the same cycle
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrl_ff      <= CTRL_RESET;                               // [RULE_21]
            expo_ff      <= EXPO_RESET;
            ovtSticky_ff <= 1'b0;
            frameCnt_ff  <= 16'h0000;
            ovtCnt_ff    <= 16'h0000;
        end else begin
            if (wrCtrl && wStrb_ff[0]) begin
                ctrl_ff <= wData_ff[CTRL_WIDTH-1:0];
            end
            if (wrExpo) begin
                expo_ff <= expoMerged[EXPO_WIDTH-1:0];                // [RULE_13]
            end
            ovtSticky_ff <= ovtEvent
                         || (ovtSticky_ff && !(wrStat && wStrb_ff[0] && wData_ff[STAT_OVT]));
            frameCnt_ff  <= startExp ? frameCnt_ff + 16'h0001 : frameCnt_ff;
            ovtCnt_ff    <= ovtEvent ? ovtCnt_ff + 16'h0001 : ovtCnt_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus handshakes

    wire [31:0] statWord = {27'h0000000, ovtSticky_ff, armed_ff, acqOn_ff,
                            expActive_ff, waiting_ff};
    wire [31:0] rdMux = (rOff == REG_CTRL) ? {26'h0000000, ctrl_ff}
                      : (rOff == REG_EXPO) ? {12'h000, expo_ff}
                      : (rOff == REG_STAT) ? statWord
                      : (rOff == REG_CNT)  ? {ovtCnt_ff, frameCnt_ff}
                      : 32'h00000000;
    wire rdOk = (rOff == REG_CTRL) || (rOff == REG_EXPO) || (rOff == REG_CMD)
             || (rOff == REG_STAT) || (rOff == REG_CNT);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            awHeld_ff  <= 1'b0;
            wHeld_ff   <= 1'b0;
            awAddr_ff  <= '0;
            wData_ff   <= 32'h00000000;
            wStrb_ff   <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
        end else begin
            awready_ff <= !awHeld_ff && !awTake;
            wready_ff  <= !wHeld_ff && !wTake;
            if (awTake) begin
                awAddr_ff <= s_axi_awaddr;
                awHeld_ff <= 1'b1;
            end else if (bvalid_ff && s_axi_bready) begin
                awHeld_ff <= 1'b0;
            end
            if (wTake) begin
                wData_ff <= s_axi_wdata;
                wStrb_ff <= s_axi_wstrb;
                wHeld_ff <= 1'b1;
            end else if (bvalid_ff && s_axi_bready) begin
                wHeld_ff <= 1'b0;
            end
            if (doWrite) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= wrOk ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h00000000;
            rresp_ff   <= RESP_OKAY;
        end else begin
            arready_ff <= !rvalid_ff && !arTake && !(arready_ff && s_axi_arvalid);
            if (arTake) begin
                rvalid_ff <= 1'b1;
                rdata_ff  <= rdMux;
                rresp_ff  <= rdOk ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    assign s_axi_awready  = awready_ff;
    assign s_axi_wready   = wready_ff;
    assign s_axi_bvalid   = bvalid_ff;
    assign s_axi_bresp    = bresp_ff;
    assign s_axi_arready  = arready_ff;
    assign s_axi_rvalid   = rvalid_ff;
    assign s_axi_rdata    = rdata_ff;
    assign s_axi_rresp    = rresp_ff;
    assign exposureActive = expActive_ff;
    assign waitingTrigger = waiting_ff;
    assign triggerArmed   = armed_ff;
    assign overtrigPulse  = ovtPulse_ff;

    ////////////////////////////////////////////////////////////////////////
    // checks

    chk_sw_start: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE_01]
        (isWait && swTrig) |=> (expActive_ff && !waiting_ff))
        else $error("software kick while waiting did not start exposure");
    chk_sw_drop: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE_05]
        (!isWait && cmdKick) |=> $stable(frameCnt_ff))
        else $error("kick outside waiting started exposure");
    chk_hw_start: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE_08]
        (isWait && hwTrig) |=> (expActive_ff && $rose(expActive_ff)))
        else $error("selected edge while waiting was not taken");
    chk_hw_ignore: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE_10]
        (isExpose && hwTrig && !expEnd) |=> (state_ff == ST_EXPOSE) && $stable(frameCnt_ff))
        else $error("edge during exposure was not ignored");
    chk_ovt_flag: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE_14]
        (isExpose && !widthRun && hwTrig) |=> (ovtPulse_ff && ovtSticky_ff))
        else $error("overtrigger not raised");
    chk_width_end: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE_15]
        (isExpose && widthRun && endEdge) |=> !expActive_ff)
        else $error("width exposure did not end on opposite edge");
    chk_timed_end: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE_13]
        (isExpose && !widthRun && timerDone) |=> (!expActive_ff && !timerRun))
        else $error("timed exposure did not end with the timer");
    chk_return_wait: assert property (@(posedge mclk) disable iff (sys_rst) // [RULE_02]
        (isExpose && expEnd && acqOn_ff && !cmdStop) |=> waiting_ff)
        else $error("did not return to waiting");
    chk_origin_reset: assert property (@(posedge mclk) // [RULE_21]
        sys_rst |=> ctrl_ff[CTRL_ORIGIN])
        else $error("origin not line 1 after reset");

    cov_sw_frame: cover property (@(posedge mclk) disable iff (sys_rst)
        isWait && swTrig ##[1:1000] timerDone);
    cov_width_frame: cover property (@(posedge mclk) disable iff (sys_rst)
        isWait && hwTrig && widthRun ##[1:1000] endEdge);
    cov_overtrig: cover property (@(posedge mclk) disable iff (sys_rst) ovtEvent);

endmodule : fst_trig_ctrl

//--- tb/fst_trig_src.sv
`timescale 1ns/1ps
module fst_trig_src (
    // clock
    input  wire logic       mclk,
    // bench command
    input  wire logic       fire,
    input  wire logic       idleLvl,
    input  wire logic [7:0] activeCyc,
    // line to device
    output logic            lineOut
);
    logic [7:0] cnt;
    initial begin
        lineOut = 1'b0;
        cnt     = 8'h00;
    end
    // one whole active phase per fire, a new one only after idle
    always @(posedge mclk) begin
        if (fire && cnt == 8'h00) begin
            lineOut <= ~idleLvl;
            cnt     <= activeCyc;
        end else if (cnt > 8'h01) begin
            cnt <= cnt - 8'h01;
        end else begin
            cnt     <= 8'h00;
            lineOut <= idleLvl;
        end
    end
endmodule : fst_trig_src

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench
    import fst_pkg::*;
;
    logic        mclk, sysRst, awvalid, wvalid, arvalid, fire, idleLvl, line;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0]  bresp, rresp, r;
    logic [7:0]  activeCyc;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        expo, waiting, armed, ovt;
    int          errTotal, cmpCount, n, w, ot0, a0, otSeen, armedCyc;

    always #12.5 mclk = ~mclk;
    fst_trig_src i_src (.mclk(mclk), .fire(fire), .idleLvl(idleLvl),
                        .activeCyc(activeCyc), .lineOut(line));
    fst_trig_ctrl i_dut (.mclk(mclk), .sys_rst(sysRst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .external_frame_trigger_line(line),
        .exposureActive(expo), .waitingTrigger(waiting), .triggerArmed(armed),
        .overtrigPulse(ovt));

    always @(posedge mclk) begin
        if (ovt === 1'b1) otSeen++;
        if (expo === 1'b1 && armed === 1'b1) armedCyc++;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            errTotal++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // ready may already be high, so valid drops at the taking edge
    task automatic axiWr(input logic [11:0] a, input logic [31:0] v);
        int k;
        k = 0;
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1;
        do begin
            @(posedge mclk);
            k++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && k < 100);
        if (bvalid !== 1'b1) chk(bvalid, 1'b1);
        r = bresp;
    endtask : axiWr
    task automatic axiRd(input logic [11:0] a);
        int k;
        k = 0;
        araddr <= a; arvalid <= 1'b1;
        do begin
            @(posedge mclk);
            k++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && k < 100);
        if (rvalid !== 1'b1) chk(rvalid, 1'b1);
        d = rdata; r = rresp;
    endtask : axiRd
    task automatic pulse(input int len);
        activeCyc <= len[7:0]; fire <= 1'b1;
        @(posedge mclk);
        fire <= 1'b0;
    endtask : pulse
    task automatic waitExp(input logic lvl, output int k);
        k = 0;
        while (expo !== lvl && k < 2000) begin
            @(posedge mclk);
            k++;
        end
        if (k >= 2000) chk(expo, lvl);
    endtask : waitExp
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmpCount, errTotal);
        if (errTotal == 0 && cmpCount > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (40000) @(posedge mclk);
        errTotal++;
        $display("wrong value at %0t: watchdog expired", $time);
        end_of_test();
    end
    initial begin
        mclk = 0; sysRst = 1; awvalid = 0; wvalid = 0; arvalid = 0; fire = 0;
        idleLvl = 0; awaddr = 0; araddr = 0; wdata = 0; activeCyc = 0;
        errTotal = 0; cmpCount = 0; otSeen = 0; armedCyc = 0;
        void'($urandom(52734));
        repeat (10) @(posedge mclk);
        sysRst <= 0;
        axiRd(REG_CTRL); chk(d, 32'h2);
        axiRd(12'h0FC); chk(r, RESP_SLVERR);
        chk(d, 32'h0);
        axiWr(12'h0FC, 32'h0); chk(r, RESP_SLVERR);
        axiWr(REG_EXPO, 32'h1); chk(r, RESP_OKAY);
        axiWr(REG_CTRL, 32'h1);
        chk(waiting, 1'b0);
        axiWr(REG_CMD, 32'h1); chk(waiting, 1'b1);
        axiWr(REG_CMD, 32'h4); chk(expo, 1'b1);
        chk(waiting, 1'b0);
        axiWr(REG_CMD, 32'h4);
        waitExp(1'b0, n); chk(waiting, 1'b1);
        axiRd(REG_CNT); chk(d, 32'h1);
        axiWr(REG_CTRL, 32'h11); axiWr(REG_CMD, 32'h4); chk(expo, 1'b0);
        // timed then trigger width, each with both polarities
        for (int i = 0; i < 4; i++) begin
            axiWr(REG_CTRL, 32'h1);
            idleLvl <= i[0];
            repeat (10) @(posedge mclk);
            axiWr(REG_CTRL, 32'h3 | (i << 2));
            w = i[1] ? 60 + $urandom % 100 : 5;
            pulse(w);
            waitExp(1'b1, n); chk(n < 8, 1'b1);
            ot0 = otSeen;
            a0 = armedCyc;
            if (!i[1]) begin
                repeat (8) @(posedge mclk);
                pulse(5);
            end
            waitExp(1'b0, n);
            if (i[1]) begin
                chk(n >= w - 3 && n <= w + 3, 1'b1);
                chk(armedCyc - a0 >= w - CYC_PER_US - 6
                    && armedCyc - a0 <= w - CYC_PER_US + 4, 1'b1);
            end else begin
                chk(n + 9 >= CYC_PER_US - 1 && n + 9 <= CYC_PER_US + 4, 1'b1);
                chk(otSeen - ot0, 1);
            end
            chk(waiting, 1'b1);
        end
        axiRd(REG_CNT); chk(d, 32'h0002_0005);
        axiRd(REG_STAT); chk(d[4], 1'b1);
        axiWr(REG_STAT, 32'h10); axiRd(REG_STAT); chk(d[4], 1'b0);
        // stop from waiting, then free running with the trigger mode off
        axiWr(REG_CMD, 32'h2); chk(waiting, 1'b0);
        axiWr(REG_CTRL, 32'h0);
        axiWr(REG_CMD, 32'h1);
        waitExp(1'b1, n); chk(n < 4, 1'b1);
        end_of_test();
    end
endmodule : testbench
